// File: verilog/origin_defs.vh
// Constants for the origin reference tracker: register indices, field
// positions, reset values and trigger select codes.
// Assumes the includer addresses registers by word index (byte address / 4).
`ifndef ORIGIN_DEFS_VH
`define ORIGIN_DEFS_VH

// Register indices; byte address is four times the index
`define IDX_SETUP 6'h01
`define IDX_EVENTS 6'h0e
`define IDX_TOLERANCE 6'h1e
`define IDX_ORIGIN 6'h20
`define IDX_POSITION 6'h21
`define IDX_STATUS 6'h22

// Reference setup fields
`define SETUP_ARM 0
`define SETUP_SEL_LSB 4
`define SETUP_SEL_MSB 7
`define SETUP_LEFT_ORG 8
`define SETUP_RIGHT_ORG 9

// Event bits (cleared by reading)
`define EVT_CAPTURED 0
`define EVT_LEFT_STOP 1
`define EVT_RIGHT_STOP 2

// Status bits
`define STAT_MISMATCH 0
`define STAT_ARM 1
`define STAT_LEFT_PEND 2
`define STAT_RIGHT_PEND 3

// Reset values
`define SETUP_RST 32'h00000000
`define TOL_RST 32'h00000000
`define ORIGIN_RST 32'h00000000

// Origin trigger select codes
`define TRIG_INDEX 4'h0
`define TRIG_NEG_LOW 4'h3
`define TRIG_POS_LOW 4'hc
`define TRIG_HI_CENTRE 4'h6
`define TRIG_HI_LEFT 4'h2
`define TRIG_HI_RIGHT 4'h4
`define TRIG_LO_CENTRE 4'h9
`define TRIG_LO_RIGHT 4'hb
`define TRIG_LO_LEFT 4'hd

`endif

// File: verilog/sync_bank.v
// Two-flop synchronisers for a group of asynchronous input levels.
// Assumes each input is a slow level; no pulse shorter than two clocks.
`timescale 1ns/1ps

module sync_bank #(
	parameter W = 4
) (
	input wire ref_clk, // System clock
	input wire reset, // Async reset, active high
	input wire [W-1:0] din, // Raw asynchronous levels
	output wire [W-1:0] dout // Synchronised levels
);

	reg [W-1:0] meta_q;
	reg [W-1:0] sync_q;

	// One pair of flops per bit; first stage feeds only the second
	genvar i;
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge ref_clk or posedge reset) begin
				if (reset) begin
					meta_q[i] <= 1'b0;
					sync_q[i] <= 1'b0;
				end else begin
					meta_q[i] <= din[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate

	assign dout = sync_q;

endmodule

// File: verilog/origin_trigger.v
// Origin trigger decoder: turns synchronised switch and index levels into
// a one-cycle fire strike and the position to capture with it.
// Assumes inputs are already synchronised to ref_clk.
`include "origin_defs.vh"
`timescale 1ns/1ps

module origin_trigger (
	input wire ref_clk, // System clock
	input wire reset, // Async reset, active high
	input wire sw, // Synchronised homing switch level
	input wire idx, // Synchronised encoder index level
	input wire [3:0] sel, // Trigger select code
	input wire signed [31:0] pos, // Current position
	output reg fire, // Trigger seen this cycle
	output reg signed [31:0] fire_pos // Position to take as origin
);

	reg sw_q;
	reg idx_q;
	reg up_q;
	reg signed [31:0] pos_q;
	reg signed [31:0] entry_q;
	wire rise;
	wire fall;
	wire up;
	wire hi_zone;
	wire enter;
	wire leave;
	wire signed [32:0] mid_sum;

	assign rise = sw & ~sw_q;
	assign fall = ~sw & sw_q;
	// Direction from the position step; holds last direction while standing
	assign up = (pos > pos_q) ? 1'b1 : ((pos < pos_q) ? 1'b0 : up_q);
	assign hi_zone = (sel == `TRIG_HI_CENTRE) | (sel == `TRIG_HI_LEFT) |
		(sel == `TRIG_HI_RIGHT);
	assign enter = hi_zone ? rise : fall;
	assign leave = hi_zone ? fall : rise;
	assign mid_sum = {entry_q[31], entry_q} + {pos[31], pos};

	// History of levels and position; zone entry point for centre codes
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			sw_q <= 1'b0;
			idx_q <= 1'b0;
			up_q <= 1'b1;
			pos_q <= 32'sh00000000;
			entry_q <= 32'sh00000000;
		end else begin
			sw_q <= sw;
			idx_q <= idx;
			up_q <= up;
			pos_q <= pos;
			if (enter) begin
				entry_q <= pos;
			end
		end
	end

	// Decode per select code; the centre is the mean of entry and exit
	always @* begin
		fire = 1'b0;
		fire_pos = pos;
		case (sel)
			`TRIG_INDEX: fire = idx & ~idx_q;
			`TRIG_NEG_LOW, `TRIG_POS_LOW: fire = rise | fall;
			`TRIG_HI_CENTRE, `TRIG_LO_CENTRE: begin
				fire = leave;
				fire_pos = mid_sum[32:1];
			end
			`TRIG_HI_LEFT, `TRIG_LO_LEFT: fire = (enter & up) | (leave & ~up);
			`TRIG_HI_RIGHT, `TRIG_LO_RIGHT: fire = (enter & ~up) | (leave & up);
			default: fire = 1'b0;
		endcase
	end

endmodule

// File: verilog/origin_reference_tracker.v
// Origin reference tracker: origin search, capture, switch monitoring
// and limit-as-origin stop events, with an APB register slave.
// Assumes current_position comes from the ramp on ref_clk; switch,
// limit and index inputs are asynchronous; limit and index active high, switch polarity per select code.
`include "origin_defs.vh"
`timescale 1ns/1ps

module origin_reference_tracker (
	input wire ref_clk, // System clock, 250 MHz
	input wire reset, // Async reset, active high
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction, 1 = write
	input wire [7:0] paddr, // APB byte address
	input wire [31:0] pwdata, // APB write data
	output reg [31:0] prdata, // APB read data
	output reg pready, // APB ready
	output reg pslverr, // APB error on unmapped address
	input wire signed [31:0] current_position, // Ramp position, microsteps
	input wire homing_switch_input, // Homing switch level
	input wire left_limit_input, // Left limit switch, active high
	input wire right_limit_input, // Right limit switch, active high
	input wire encoder_index_channel, // Encoder index level
	output reg origin_mismatch_flag, // Switch level disagrees with origin
	output reg origin_captured_event, // Latched capture event
	output reg left_stop_event, // Latched left stop event
	output reg right_stop_event // Latched right stop event
);

	// Synchronised inputs
	wire [3:0] raw_in;
	wire [3:0] sync_in;
	wire sw_s;
	wire left_s;
	wire right_s;
	wire idx_s;

	// Configuration and state
	reg arm_q;
	reg [3:0] sel_q;
	reg left_org_q;
	reg right_org_q;
	reg [31:0] tol_q;
	reg signed [31:0] origin_q;
	reg cap_done_q;
	reg left_q;
	reg right_q;
	reg left_pend_q;
	reg right_pend_q;
	reg [31:0] rd_snap_q;

	// Derived signals
	wire home_sw;
	wire fire;
	wire signed [31:0] fire_pos;
	wire capture;
	wire signed [33:0] pos_x;
	wire signed [33:0] band_lo;
	wire signed [33:0] band_hi;
	wire below;
	wire above;
	wire in_band;
	wire left_hit;
	wire right_hit;
	wire [5:0] idx;
	wire aligned;
	wire setup_ph;
	wire done;
	wire wr;
	wire rd_events;
	reg known;
	reg check;
	reg expect_lvl;
	reg mapped;
	reg [31:0] rd_val;
	reg [2:0] evt_d;

	// Two-flop synchronisers ahead of every edge and level check
	assign raw_in = {encoder_index_channel, right_limit_input, left_limit_input,
		homing_switch_input};

	sync_bank #(
		.W(4)
	) u_sync (
		.ref_clk(ref_clk),
		.reset(reset),
		.din(raw_in),
		.dout(sync_in)
	);

	assign sw_s = sync_in[0];
	assign left_s = sync_in[1];
	assign right_s = sync_in[2];
	assign idx_s = sync_in[3];

	// Either limit may stand in for the homing switch; left takes priority
	assign home_sw = left_org_q ? left_s : (right_org_q ? right_s : sw_s);

	origin_trigger u_trig (
		.ref_clk(ref_clk),
		.reset(reset),
		.sw(home_sw),
		.idx(idx_s),
		.sel(sel_q),
		.pos(current_position),
		.fire(fire),
		.fire_pos(fire_pos)
	);

	// Only the first trigger after arming counts
	assign capture = fire & arm_q & ~cap_done_q;

	// Tolerance band in 34 bits so neither bound wraps
	assign pos_x = {{2{current_position[31]}}, current_position};
	assign band_lo = {{2{origin_q[31]}}, origin_q} - {2'b00, tol_q};
	assign band_hi = {{2{origin_q[31]}}, origin_q} + {2'b00, tol_q};
	assign below = pos_x < band_lo;
	assign above = pos_x > band_hi;
	assign in_band = ~below & ~above;

	// Expected switch level outside the band, per select code
	always @* begin
		known = 1'b1;
		expect_lvl = 1'b0;
		case (sel_q)
			`TRIG_NEG_LOW: expect_lvl = above;
			`TRIG_POS_LOW: expect_lvl = below;
			`TRIG_HI_CENTRE, `TRIG_HI_LEFT, `TRIG_HI_RIGHT: expect_lvl = 1'b0;
			`TRIG_LO_CENTRE, `TRIG_LO_LEFT, `TRIG_LO_RIGHT: expect_lvl = 1'b1;
			`TRIG_INDEX: known = 1'b0;
			default: known = 1'b0;
		endcase
		check = known & ~in_band;
	end

	// Limit activation; when that limit is the origin, activation followed by entry into the band
	assign left_hit = left_org_q ? (left_pend_q & in_band) : (left_s & ~left_q);
	assign right_hit = right_org_q ? (right_pend_q & in_band) : (right_s & ~right_q);

	// APB decode; one wait-free access phase follows each setup
	assign idx = paddr[7:2];
	assign aligned = (paddr[1:0] == 2'b00);
	assign setup_ph = psel & ~penable;
	assign done = psel & penable & pready;
	assign wr = done & pwrite & ~pslverr;
	assign rd_events = done & ~pwrite & ~pslverr & (idx == `IDX_EVENTS);

	// Read mux, also the map of valid addresses
	always @* begin
		mapped = aligned;
		rd_val = 32'h00000000;
		case (idx)
			`IDX_SETUP: begin
				rd_val[`SETUP_ARM] = arm_q;
				rd_val[`SETUP_SEL_MSB:`SETUP_SEL_LSB] = sel_q;
				rd_val[`SETUP_LEFT_ORG] = left_org_q;
				rd_val[`SETUP_RIGHT_ORG] = right_org_q;
			end
			`IDX_EVENTS: begin
				rd_val[`EVT_CAPTURED] = origin_captured_event;
				rd_val[`EVT_LEFT_STOP] = left_stop_event;
				rd_val[`EVT_RIGHT_STOP] = right_stop_event;
			end
			`IDX_TOLERANCE: rd_val = tol_q;
			`IDX_ORIGIN: rd_val = origin_q;
			`IDX_POSITION: rd_val = current_position;
			`IDX_STATUS: begin
				rd_val[`STAT_MISMATCH] = origin_mismatch_flag;
				rd_val[`STAT_ARM] = arm_q;
				rd_val[`STAT_LEFT_PEND] = left_pend_q;
				rd_val[`STAT_RIGHT_PEND] = right_pend_q;
			end
			default: mapped = 1'b0;
		endcase
		if (!mapped) begin
			rd_val = 32'h00000000;
		end
	end

	// Bus answer registered in the setup cycle, ready in the first access cycle
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			rd_snap_q <= 32'h00000000;
		end else begin
			pready <= setup_ph;
			if (setup_ph) begin
				pslverr <= ~mapped;
				prdata <= pwrite ? 32'h00000000 : rd_val;
				rd_snap_q <= rd_val;
			end else if (done) begin
				pslverr <= 1'b0;
			end
		end
	end

	// Events: clear only what the read showed, so a new set is never lost
	always @* begin
		evt_d = {right_stop_event, left_stop_event, origin_captured_event};
		if (rd_events) begin
			evt_d = evt_d & ~rd_snap_q[2:0];
		end
		evt_d = evt_d | {right_hit, left_hit, capture};
	end

	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			origin_captured_event <= 1'b0;
			left_stop_event <= 1'b0;
			right_stop_event <= 1'b0;
		end else begin
			origin_captured_event <= evt_d[`EVT_CAPTURED];
			left_stop_event <= evt_d[`EVT_LEFT_STOP];
			right_stop_event <= evt_d[`EVT_RIGHT_STOP];
		end
	end

	// Setup and tolerance registers; arm self-clears after capture is acked
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			arm_q <= 1'b0;
			sel_q <= 4'h0;
			left_org_q <= 1'b0;
			right_org_q <= 1'b0;
			tol_q <= `TOL_RST;
			cap_done_q <= 1'b0;
		end else begin
			if (wr && idx == `IDX_SETUP) begin
				// A software write wins over the automatic clear
				arm_q <= pwdata[`SETUP_ARM];
				sel_q <= pwdata[`SETUP_SEL_MSB:`SETUP_SEL_LSB];
				left_org_q <= pwdata[`SETUP_LEFT_ORG];
				right_org_q <= pwdata[`SETUP_RIGHT_ORG];
				cap_done_q <= 1'b0;
			end else if (cap_done_q && !origin_captured_event) begin
				arm_q <= 1'b0;
				cap_done_q <= 1'b0;
			end else if (capture) begin
				cap_done_q <= 1'b1;
			end
			if (wr && idx == `IDX_TOLERANCE) begin
				tol_q <= pwdata;
			end
		end
	end

	// Origin: hardware capture, or software write which takes precedence
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			origin_q <= `ORIGIN_RST;
		end else if (wr && idx == `IDX_ORIGIN) begin
			origin_q <= pwdata;
		end else if (capture) begin
			origin_q <= fire_pos;
		end
	end

	// Limit pending flags: armed by activation, spent on band entry
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			left_q <= 1'b0;
			right_q <= 1'b0;
			left_pend_q <= 1'b0;
			right_pend_q <= 1'b0;
		end else begin
			left_q <= left_s;
			right_q <= right_s;
			if (!left_org_q || !left_s || in_band) begin
				left_pend_q <= 1'b0;
			end else if (!left_q) begin
				left_pend_q <= 1'b1;
			end
			if (!right_org_q || !right_s || in_band) begin
				right_pend_q <= 1'b0;
			end else if (!right_q) begin
				right_pend_q <= 1'b1;
			end
		end
	end

	// Mismatch is a live level, held low outside checkable codes
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			origin_mismatch_flag <= 1'b0;
		end else begin
			origin_mismatch_flag <= check & (home_sw != expect_lvl);
		end
	end

endmodule

// File: verification/origin_chk.sv
// Port checker for the origin reference tracker, bound to its top.
// Assumes far-side pins are held steady for several clocks at a time.
`timescale 1ns/1ps

module origin_chk (
	input wire ref_clk, // Clock
	input wire reset, // Async reset
	input wire psel, // APB select
	input wire penable, // APB enable
	input wire pwrite, // APB direction
	input wire [7:0] paddr, // APB address
	input wire [31:0] prdata, // Read data
	input wire pready, // Ready
	input wire pslverr, // Error
	input wire homing_switch_input, // Switch
	input wire left_limit_input, // Left limit
	input wire right_limit_input, // Right limit
	input wire encoder_index_channel, // Index
	input wire origin_captured_event, // Capture
	input wire left_stop_event, // Left stop
	input wire right_stop_event // Right stop
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);
	logic [3:0] pins_q;
	logic [3:0] age_q;
	logic [3:0] age_d;
	wire [3:0] pins;
	wire evt_rd;
	// Cycles since a far-side pin moved; a capture needs a recent cause
	assign pins = {homing_switch_input, left_limit_input, right_limit_input, encoder_index_channel};
	assign age_d = (pins_q != pins) ? 4'h0 : age_q + {3'h0, age_q != 4'hf};
	always @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			pins_q <= 4'h0;
			age_q <= 4'hf;
		end else begin
			pins_q <= pins;
			age_q <= age_d;
		end
	end
	// Completed read of the event register
	assign evt_rd = psel && penable && pready && !pwrite && paddr == 8'h38;
	ready_setup_a: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	ready_cause_a: assert property ($rose(pready) |-> $past(psel && !penable))
		else $error("ready without setup");
	misalign_err_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
		else $error("misaligned access not refused");
	err_data_a: assert property (pready && (pwrite || pslverr) |-> prdata == 32'h0)
		else $error("read data not zero");
	capture_cause_a: assert property ($rose(origin_captured_event) |-> age_q < 4'h6)
		else $error("capture without pin change");
	capture_sticky_a: assert property ($fell(origin_captured_event) |-> $past(evt_rd))
		else $error("capture event dropped unread");
	left_sticky_a: assert property ($fell(left_stop_event) |-> $past(evt_rd))
		else $error("left event dropped unread");
	right_sticky_a: assert property ($fell(right_stop_event) |-> $past(evt_rd))
		else $error("right event dropped unread");
	read_clear_a: assert property (evt_rd && prdata[0] |=> !origin_captured_event || age_q < 4'h6)
		else $error("capture event not cleared");
	left_cause_a: assert property ($rose(left_stop_event) |-> $past(left_limit_input, 2))
		else $error("left event without limit");
	right_cause_a: assert property ($rose(right_stop_event) |-> $past(right_limit_input, 2))
		else $error("right event without limit");
endmodule

bind origin_reference_tracker origin_chk i_chk (.ref_clk(ref_clk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .homing_switch_input(homing_switch_input),
	.left_limit_input(left_limit_input), .right_limit_input(right_limit_input),
	.encoder_index_channel(encoder_index_channel), .origin_captured_event(origin_captured_event),
	.left_stop_event(left_stop_event), .right_stop_event(right_stop_event));

// File: verification/switch_model.sv
// Far-side model: homing switch zone, two limit switches, index mark.
// Assumes the ramp position steps slowly; levels follow it directly.
`timescale 1ns/1ps

module switch_model (
	input wire signed [31:0] pos, // Ramp position
	input wire inv, // Switch wired low-active
	output wire hsw, // Homing switch level
	output wire llim, // Left limit level
	output wire rlim, // Right limit level
	output wire idx // Encoder index level
);
	// Zone 300..320, index at 310; limits overlap the zone on purpose
	assign hsw = inv ^ (pos >= 300 && pos <= 320);
	assign llim = pos <= 310;
	assign rlim = pos >= 290;
	assign idx = pos == 310;
endmodule

// File: verification/testbench.sv
// Self-checking bench for the origin reference tracker over APB.
// Assumes the switch model on the far side and one 250 MHz clock.
`timescale 1ns/1ps

module testbench;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, inv = 1'h0, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, rd;
	logic signed [31:0] pos = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, hsw, llim, rlim, idx, mism, cap, lev, rev;
	int bad_count = 0;
	int checks = 0;

	// Free-running clock, 4 ns period
	always #2 ref_clk = ~ref_clk;

	origin_reference_tracker i_dut (.ref_clk(ref_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .current_position(pos),
		.homing_switch_input(hsw), .left_limit_input(llim), .right_limit_input(rlim),
		.encoder_index_channel(idx), .origin_mismatch_flag(mism), .origin_captured_event(cap),
		.left_stop_event(lev), .right_stop_event(rev));
	switch_model i_sw (.pos(pos), .inv(inv), .hsw(hsw), .llim(llim), .rlim(rlim), .idx(idx));

	task automatic give_verdict;
		if (bad_count == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] want);
		checks++;
		if (got !== want) begin
			bad_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, want);
		end
	endtask

	// One APB transfer; request held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Only a ready that never came is a timeout
		if (pready !== 1'h1) begin
			bad_count++;
			give_verdict;
		end
	endtask

	// Ramp one microstep per six clocks so every pin change settles
	task automatic move(input int target);
		while (pos != target) begin
			pos <= (pos < target) ? pos + 1 : pos - 1;
			repeat (6) @(posedge ref_clk);
		end
		repeat (6) @(posedge ref_clk);
	endtask

	task automatic t_regs;
		check({cap, lev, rev, mism}, 32'h0);
		apb(1'h0, 8'h04, 32'h0);
		check(rd, 32'h0);
		apb(1'h1, 8'h78, 32'h5);
		apb(1'h0, 8'h78, 32'h0);
		check(rd, 32'h5);
		apb(1'h1, 8'h80, 32'h12c);
		apb(1'h0, 8'h80, 32'h0);
		check(rd, 32'h12c);
		apb(1'h1, 8'h84, 32'h7);
		apb(1'h0, 8'h84, 32'h0);
		check(rd, 32'h0);
		apb(1'h0, 8'h3c, 32'h0);
		check(err, 1'h1);
		apb(1'h1, 8'h06, 32'h1);
		check(err, 1'h1);
	endtask

	// Every trigger code arms once; the zone runs 300..320
	task automatic t_capture;
		logic [3:0] code [9] = '{4'h0, 4'h3, 4'hc, 4'h2, 4'h4, 4'h6, 4'hd, 4'hb, 4'h9};
		int want [9] = '{310, 300, 300, 300, 321, 310, 300, 321, 310};
		for (int i = 0; i < 9; i++) begin
			inv <= (i > 5);
			move(280);
			apb(1'h1, 8'h04, {24'h0, code[i], 4'h1});
			move(340);
			check(cap, 1'h1);
			apb(1'h0, 8'h80, 32'h0);
			check(rd, want[i]);
			apb(1'h0, 8'h38, 32'h0);
			check(rd[0], 1'h1);
			// The clear lands on the completing edge; look one edge later
			@(posedge ref_clk);
			check(cap, 1'h0);
			repeat (2) @(posedge ref_clk);
			apb(1'h0, 8'h88, 32'h0);
			check(rd[1], 1'h0);
		end
	endtask

	// Origin 300, band 5: levels on and just past both band edges
	task automatic t_mismatch;
		logic [3:0] code [10] = '{3, 3, 3, 3, 3, 3, 3, 12, 12, 0};
		logic flip [10] = '{0, 0, 1, 1, 1, 1, 0, 0, 0, 0};
		int at [10] = '{330, 306, 306, 305, 295, 294, 294, 330, 310, 330};
		logic want [10] = '{1, 0, 1, 0, 0, 1, 0, 0, 1, 0};
		apb(1'h1, 8'h80, 32'h12c);
		for (int i = 0; i < 10; i++) begin
			inv <= flip[i];
			apb(1'h1, 8'h04, {24'h0, code[i], 4'h0});
			move(at[i]);
			check(mism, want[i]);
		end
	endtask

	task automatic t_limits;
		apb(1'h1, 8'h04, 32'h100);
		move(400);
		apb(1'h0, 8'h38, 32'h0);
		move(306);
		check(lev, 1'h0);
		apb(1'h0, 8'h88, 32'h0);
		check(rd[2], 1'h1);
		move(305);
		check(lev, 1'h1);
		apb(1'h1, 8'h04, 32'h200);
		move(200);
		apb(1'h0, 8'h38, 32'h0);
		move(294);
		check(rev, 1'h0);
		apb(1'h0, 8'h88, 32'h0);
		check(rd[3], 1'h1);
		move(295);
		check(rev, 1'h1);
	endtask

	// Reset, then the scenarios in order
	initial begin
		repeat (10) @(posedge ref_clk);
		reset <= 1'h0;
		t_regs;
		t_capture;
		t_mismatch;
		t_limits;
		give_verdict;
	end
endmodule
